/* ussc_pkg.sv */
// Package: operation codes, status field layout and reset values for the unsigned SIMD subtract unit
package ussc_pkg;

	// Operation select, one-hot
	typedef enum logic [6:0] {
		USSC_OP_NONE = 7'h00,
		USSC_OP_SUB_UNS_HALF_WRAP = 7'h01,
		USSC_OP_SUB_UNS_HALF_SAT = 7'h02,
		USSC_OP_SUB_UNS_BYTE_WRAP = 7'h04,
		USSC_OP_SUB_UNS_BYTE_SAT = 7'h08,
		USSC_OP_SUB_UNS_BYTE_HALVE = 7'h10,
		USSC_OP_SUB_UNS_BYTE_HALVE_ROUND = 7'h20,
		USSC_OP_WRITE_SIMD_STATUS_FIELDS = 7'h40
	} ussc_op_t;

	// Issue bundle from decode
	typedef struct packed {
		logic valid;
		ussc_op_t op;
		logic [31:0] src_a;
		logic [31:0] src_b;
		logic [4:0] dest_sel;
		logic [9:0] mask;
		logic single_operand;
	} ussc_issue_t;

	// Result bundle back to the register file
	typedef struct packed {
		logic valid;
		logic [4:0] dest_sel;
		logic [31:0] data;
	} ussc_result_t;

	// Status field positions
	localparam int USSC_POS_LSB = 0;
	localparam int USSC_POS_MSB = 5;
	localparam int USSC_SCOUNT_LSB = 7;
	localparam int USSC_SCOUNT_MSB = 12;
	localparam int USSC_CARRY_BIT = 13;
	localparam int USSC_EXTRACT_FAIL_IND_BIT = 14;
	localparam int USSC_OUFLAG_LSB = 16;
	localparam int USSC_OUFLAG_MSB = 23;
	localparam int USSC_CCOND_LSB = 24;
	localparam int USSC_CCOND_MSB = 31;
	localparam int USSC_SUB_OUFLAG_BIT = 20;
	localparam int USSC_MASK_USED = 6;

	// Field write enables, one per used mask bit (0 to 5)
	localparam logic [31:0] USSC_FIELD_MASK0 = 32'h0000003f;
	localparam logic [31:0] USSC_FIELD_MASK1 = 32'h00001f80;
	localparam logic [31:0] USSC_FIELD_MASK2 = 32'h00002000;
	localparam logic [31:0] USSC_FIELD_MASK3 = 32'h00ff0000;
	localparam logic [31:0] USSC_FIELD_MASK4 = 32'hff000000;
	localparam logic [31:0] USSC_FIELD_MASK5 = 32'h00004000;

	localparam logic [9:0] USSC_MASK_ALL = 10'h01f;
	localparam logic [31:0] USSC_STATUS_RESET = 32'h00000000;
	localparam int USSC_BYTE_LANES = 4;
	localparam int USSC_HALF_LANES = 2;

endpackage

/* ussc_lane_sub.sv */
// Leaf: one unsigned subtract lane with wrap, saturate, halve and round forms
`timescale 1ns/1ps
module ussc_lane_sub import ussc_pkg::*; #(
	parameter int W = 8
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic saturate,
	input wire logic halve,
	input wire logic round_up,
	output logic [W-1:0] diff,
	output logic borrow
);

	logic [W:0] wide; // Zero-extended difference, top bit is the borrow
	logic [W:0] rounded; // Difference with the discarded bit rounded

	// Lane arithmetic
	always_comb begin
		wide = {1'b0, a} - {1'b0, b};
		rounded = wide + {{W{1'b0}}, round_up};
		borrow = wide[W];
		if (halve) begin
			// Keep the borrow as the new top bit, so negative results stay two's complement
			diff = rounded[W:1];
		end else if (saturate && wide[W]) begin
			diff = '0;
		end else begin
			// Wrap: low bits only, modulo the lane width
			diff = wide[W-1:0];
		end
	end

endmodule

/* ussc_core.sv */
// Main: unsigned SIMD subtract execution unit with its status/control register
//
// Function
// - Halfword wrap subtract, independent lanes, low 16
// - Halfword: first selector subtracted from second
// - Halfword saturate: borrowing lane becomes zero
// - Halfword borrow in any lane sets bit 20
// - Byte wrap: first minus second, modulo 256
// - Byte saturate: borrowing lane becomes zero
// - Byte borrow in any lane sets bit 20
// - Halving byte: 9-bit difference shifted right one
// - Rounding halving adds one before the shift
// - Halving byte leaves status untouched
// - No operand-dependent exceptions from subtracts
// - Halving only raises reserved or disabled exceptions
// - Set mask bit loads field from source
// - Mask bits 6 through 9 ignored
// - Mask bit to status field mapping
// - Single-operand field write uses mask 0x1f
`timescale 1ns/1ps
module ussc_core import ussc_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire ussc_issue_t issue,
	input wire logic simd_enable,
	input wire logic simd_present,
	output ussc_result_t result,
	output logic [31:0] simd_status_ctrl,
	output logic exc_reserved_instr,
	output logic exc_simd_disabled
);

	logic [31:0] simd_status_ctrl_r; // Status/control register
	logic [31:0] simd_status_ctrl_nxt;
	ussc_result_t result_r; // Registered write-back
	ussc_result_t result_nxt;
	logic exc_ri_r; // Reserved-instruction exception, one cycle
	logic exc_dis_r; // Unit-disabled exception, one cycle

	logic [31:0] half_minuend; // Halfword operands after the order swap
	logic [31:0] half_subtrahend;
	logic [31:0] half_diff; // Per-lane halfword results
	logic [1:0] half_borrow;
	logic [31:0] byte_diff; // Per-lane byte results
	logic [3:0] byte_borrow;

	logic op_half; // Decoded groups
	logic op_byte_flag;
	logic op_halve;
	logic op_write;
	logic known_op;
	logic accepted; // Issue actually executes
	logic [9:0] eff_mask; // Mask after the single-operand idiom
	logic [31:0] write_sel; // Status bits replaced by a field write

	// Operation groups
	always_comb begin
		op_half = (issue.op == USSC_OP_SUB_UNS_HALF_WRAP) || (issue.op == USSC_OP_SUB_UNS_HALF_SAT);
		op_byte_flag = (issue.op == USSC_OP_SUB_UNS_BYTE_WRAP) || (issue.op == USSC_OP_SUB_UNS_BYTE_SAT);
		op_halve = (issue.op == USSC_OP_SUB_UNS_BYTE_HALVE) || (issue.op == USSC_OP_SUB_UNS_BYTE_HALVE_ROUND);
		op_write = (issue.op == USSC_OP_WRITE_SIMD_STATUS_FIELDS);
		known_op = op_half || op_byte_flag || op_halve || op_write;
		// Only an unknown op or a missing or disabled unit stops an issue; operand values never do
		accepted = issue.valid && known_op && simd_present && simd_enable;
	end

	// Halfword path subtracts the first selector's lanes from the second's
	always_comb begin
		half_minuend = issue.src_b;
		half_subtrahend = issue.src_a;
	end

	// Two halfword lanes, each its own borrow chain
	generate
		for (genvar h = 0; h < USSC_HALF_LANES; h++) begin : g_half
			ussc_lane_sub #(
				.W(16)
			) u_half (
				.a(half_minuend[16*h +: 16]),
				.b(half_subtrahend[16*h +: 16]),
				.saturate(issue.op == USSC_OP_SUB_UNS_HALF_SAT),
				.halve(1'b0),
				.round_up(1'b0),
				.diff(half_diff[16*h +: 16]),
				.borrow(half_borrow[h])
			);
		end
	endgenerate

	// Four byte lanes; byte forms use first minus second
	generate
		for (genvar k = 0; k < USSC_BYTE_LANES; k++) begin : g_byte
			ussc_lane_sub #(
				.W(8)
			) u_byte (
				.a(issue.src_a[8*k +: 8]),
				.b(issue.src_b[8*k +: 8]),
				.saturate(issue.op == USSC_OP_SUB_UNS_BYTE_SAT),
				.halve(op_halve),
				.round_up(issue.op == USSC_OP_SUB_UNS_BYTE_HALVE_ROUND),
				.diff(byte_diff[8*k +: 8]),
				.borrow(byte_borrow[k])
			);
		end
	endgenerate

	// Effective mask; upper mask bits never reach the field decode
	always_comb begin
		eff_mask = issue.single_operand ? USSC_MASK_ALL : issue.mask;
		write_sel = '0;
		// Only the low six bits are looked at
		if (eff_mask[0]) begin
			write_sel = write_sel | USSC_FIELD_MASK0;
		end
		if (eff_mask[1]) begin
			write_sel = write_sel | USSC_FIELD_MASK1;
		end
		if (eff_mask[2]) begin
			write_sel = write_sel | USSC_FIELD_MASK2;
		end
		if (eff_mask[3]) begin
			write_sel = write_sel | USSC_FIELD_MASK3;
		end
		if (eff_mask[4]) begin
			write_sel = write_sel | USSC_FIELD_MASK4;
		end
		if (eff_mask[USSC_MASK_USED-1]) begin
			write_sel = write_sel | USSC_FIELD_MASK5;
		end
	end

	// Next status value
	always_comb begin
		simd_status_ctrl_nxt = simd_status_ctrl_r;
		if (accepted) begin
			if (op_write) begin
				// Mapped fields load from the same source positions, others hold
				simd_status_ctrl_nxt = (simd_status_ctrl_r & ~write_sel) | (issue.src_b & write_sel);
			end else if (op_half) begin
				// Sticky: a borrow sets bit 20, no borrow leaves it as it was
				if (|half_borrow) begin
					simd_status_ctrl_nxt[USSC_SUB_OUFLAG_BIT] = 1'b1;
				end
			end else if (op_byte_flag) begin
				if (|byte_borrow) begin
					simd_status_ctrl_nxt[USSC_SUB_OUFLAG_BIT] = 1'b1;
				end
			end else begin
				// Halving forms cannot overflow and leave the register alone
				simd_status_ctrl_nxt = simd_status_ctrl_r;
			end
		end
		// Bit 6 and 15 have no mask bit; 15 is hard zero
		simd_status_ctrl_nxt[15] = 1'b0;
		simd_status_ctrl_nxt[6] = simd_status_ctrl_r[6];
	end

	// Status register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			simd_status_ctrl_r <= USSC_STATUS_RESET;
		end else begin
			simd_status_ctrl_r <= simd_status_ctrl_nxt;
		end
	end

	// Write-back selection
	always_comb begin
		result_nxt.valid = accepted && !op_write;
		result_nxt.dest_sel = issue.dest_sel;
		if (op_half) begin
			result_nxt.data = half_diff;
		end else begin
			result_nxt.data = byte_diff;
		end
	end

	// Write-back register, one cycle after issue
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			result_r <= '0;
		end else begin
			result_r <= result_nxt;
		end
	end

	// Exceptions: only the two structural kinds are raised
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			exc_ri_r <= 1'b0;
			exc_dis_r <= 1'b0;
		end else begin
			// Unknown op or absent unit counts as reserved
			exc_ri_r <= issue.valid && (!known_op || !simd_present);
			// Present but switched off
			exc_dis_r <= issue.valid && known_op && simd_present && !simd_enable;
		end
	end

	// Outputs straight from flops
	always_comb begin
		result = result_r;
		simd_status_ctrl = simd_status_ctrl_r;
		exc_reserved_instr = exc_ri_r;
		exc_simd_disabled = exc_dis_r;
	end

endmodule

/* ussc_core_props.sv */
// Port assertions for the unsigned SIMD subtract unit
`timescale 1ns/1ps
module ussc_core_props import ussc_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire ussc_issue_t issue,
	input wire logic simd_enable,
	input wire logic simd_present,
	input wire ussc_result_t result,
	input wire logic [31:0] simd_status_ctrl,
	input wire logic exc_reserved_instr,
	input wire logic exc_simd_disabled
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Accepted request, split into field write and subtract
	wire ok = issue.valid && simd_present && simd_enable && $onehot(issue.op);
	wire wr = ok && issue.op[6];
	wire sub = ok && !issue.op[6];
	AST_RESULT: assert property (sub |=> result.valid && !exc_reserved_instr && !exc_simd_disabled)
		else $error("subtract gave no clean result");
	AST_HALF_FLAG: assert property (sub && issue.op[1:0] != 0 && issue.src_a[15:0] > issue.src_b[15:0]
		|=> simd_status_ctrl[20]) else $error("halfword borrow not flagged");
	AST_HALF_SAT: assert property (sub && issue.op[1] && issue.src_a[31:16] > issue.src_b[31:16]
		|=> result.data[31:16] == 16'h0000) else $error("halfword lane not clamped");
	AST_BYTE_SAT: assert property (sub && issue.op[3] && issue.src_a[7:0] < issue.src_b[7:0]
		|=> result.data[7:0] == 8'h00 && simd_status_ctrl[20]) else $error("byte lane not clamped");
	AST_HALVE_KEEP: assert property (sub && issue.op[5:4] != 0 |=> $stable(simd_status_ctrl))
		else $error("halving op touched status");
	AST_STICKY: assert property (!wr |=> !$fell(simd_status_ctrl[20]))
		else $error("flag cleared without field write");
	AST_MASK_IGN: assert property (wr && issue.mask[5:0] == 0 && !issue.single_operand
		|=> $stable(simd_status_ctrl)) else $error("upper mask bits acted");
	AST_RSVD_BITS: assert property (wr |=> !simd_status_ctrl[15] && $stable(simd_status_ctrl[6]))
		else $error("unmapped status bit changed");
	AST_DISABLED: assert property (issue.valid && simd_present && !simd_enable && $onehot(issue.op)
		|=> exc_simd_disabled && !result.valid) else $error("disabled unit not refused");
	cover property (sub ##1 simd_status_ctrl[20]);
	cover property (wr);
	cover property (exc_reserved_instr);
	cover property (exc_simd_disabled);
endmodule
bind ussc_core ussc_core_props i_ussc_core_props(.mclk, .resetn, .issue, .simd_enable, .simd_present,
	.result, .simd_status_ctrl, .exc_reserved_instr, .exc_simd_disabled);

/* ussc_rf_model.sv */
// Register file stand-in: counts write-backs from the unit
`timescale 1ns/1ps
module ussc_rf_model import ussc_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire ussc_result_t result,
	output int wr_count
);
	// Each result pulse is one register write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) wr_count <= 0;
		else if (result.valid) wr_count <= wr_count + 1;
	end
endmodule

/* ussc_core_tb.sv */
// Testbench for the unsigned SIMD subtract unit
`timescale 1ns/1ps
module ussc_core_tb import ussc_pkg::*; ;
	logic mclk = 0, resetn = 0, simd_enable = 1, simd_present = 1;
	ussc_issue_t issue = '0;
	ussc_result_t result;
	logic [31:0] simd_status_ctrl, exp;
	logic exc_reserved_instr, exc_simd_disabled;
	int bad_count = 0, n_tests = 0, wr_count, cnt;
	ussc_core i_ussc_core(.mclk, .resetn, .issue, .simd_enable, .simd_present, .result,
		.simd_status_ctrl, .exc_reserved_instr, .exc_simd_disabled);
	ussc_rf_model i_ussc_rf_model(.mclk, .resetn, .result, .wr_count);
	initial forever #2 mclk = ~mclk;
	task automatic check(logic [31:0] seen, logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One issue at a falling edge; answer is settled at the next one
	task automatic do_op(ussc_op_t op, logic [31:0] a, logic [31:0] b, logic [9:0] m, logic so = 0);
		@(negedge mclk);
		issue <= '{1'b1, op, a, b, 5'h07, m, so};
		@(negedge mclk);
		issue.valid <= 1'b0;
	endtask
	task automatic clr();
		do_op(USSC_OP_WRITE_SIMD_STATUS_FIELDS, 0, 0, 10'h008);
	endtask
	task automatic sub_chk(ussc_op_t op, logic [31:0] a, logic [31:0] b, logic [31:0] d, logic f);
		do_op(op, a, b, 0);
		check({result.valid, result.dest_sel, result.data}, {1'b1, 5'h07, d});
		check({exc_reserved_instr, exc_simd_disabled, simd_status_ctrl[20]}, {2'b00, f});
	endtask
	task automatic t_byte();
		clr();
		sub_chk(USSC_OP_SUB_UNS_BYTE_WRAP, 32'h80402010, 32'h10101010, 32'h70301000, 0);
		sub_chk(USSC_OP_SUB_UNS_BYTE_WRAP, 32'h00ff0001, 32'h01010002, 32'hfffe00ff, 1);
		clr();
		sub_chk(USSC_OP_SUB_UNS_BYTE_SAT, 32'h00ff0001, 32'h01010002, 32'h00fe0000, 1);
	endtask
	task automatic t_half();
		clr();
		sub_chk(USSC_OP_SUB_UNS_HALF_WRAP, 32'h00050003, 32'h00070003, 32'h00020000, 0);
		sub_chk(USSC_OP_SUB_UNS_HALF_WRAP, 32'h00010005, 32'h00020003, 32'h0001fffe, 1);
		sub_chk(USSC_OP_SUB_UNS_HALF_SAT, 32'h00050003, 32'h00070003, 32'h00020000, 1);
		clr();
		sub_chk(USSC_OP_SUB_UNS_HALF_SAT, 32'h00030005, 32'h00020003, 32'h00000000, 1);
	endtask
	// Flag cleared first, so a borrowing halving lane that wrongly sets it is caught
	task automatic t_halve();
		clr();
		sub_chk(USSC_OP_SUB_UNS_BYTE_HALVE, 32'h00ff0003, 32'h01000000, 32'hff7f0001, 0);
		sub_chk(USSC_OP_SUB_UNS_BYTE_HALVE_ROUND, 32'h00ff0003, 32'h01000000, 32'h00800002, 0);
	endtask
	// Field mapping table, one entry per used mask bit (0 to 5)
	task automatic t_fields();
		logic [31:0] fm [6] = '{32'h3f, 32'h1f80, 32'h2000, 32'hff0000, 32'hff000000, 32'h4000};
		exp = 0;
		do_op(USSC_OP_WRITE_SIMD_STATUS_FIELDS, 0, 0, 10'h000, 1);
		check(simd_status_ctrl, 0);
		do_op(USSC_OP_WRITE_SIMD_STATUS_FIELDS, 0, '1, 10'h3c0);
		check(simd_status_ctrl, 0);
		for (int i = 0; i < 6; i++) begin
			exp |= fm[i];
			do_op(USSC_OP_WRITE_SIMD_STATUS_FIELDS, 0, '1, 10'(1 << i));
			check(simd_status_ctrl, exp);
		end
		do_op(USSC_OP_WRITE_SIMD_STATUS_FIELDS, 0, 0, 10'h000, 1);
		check(simd_status_ctrl, 32'h00004000);
	endtask
	task automatic t_refuse();
		cnt = wr_count;
		simd_enable = 0;
		do_op(USSC_OP_SUB_UNS_HALF_WRAP, 1, 0, 0);
		check(exc_simd_disabled, 1);
		simd_enable = 1;
		simd_present = 0;
		do_op(USSC_OP_SUB_UNS_HALF_WRAP, 1, 0, 0);
		check(exc_reserved_instr, 1);
		simd_present = 1;
		do_op(ussc_op_t'(7'h03), 1, 0, 0);
		check({exc_reserved_instr, simd_status_ctrl}, {1'b1, 32'h00004000});
		check(wr_count, cnt);
	endtask
	// Hang guard, well beyond the 56 or so cycles used
	initial begin
		#20000;
		bad_count++;
		conclude();
	end
	initial begin
		repeat (4) @(negedge mclk);
		resetn = 1;
		t_byte();
		t_half();
		t_halve();
		t_fields();
		t_refuse();
		conclude();
	end
endmodule
